//--- hdl/lrsp_pkg.sv
/*
 * shared constants for the lite register slave port: widths, response codes,
 * storage depth and the fixed attribute values of the lite subset.
 * assumes both ends are compiled after this package.
 */
package lrsp_pkg;
    localparam int LRSP_ADDR_W = 12;
    localparam int LRSP_DATA_W = 32;
    localparam int LRSP_STRB_W = LRSP_DATA_W / 8;
    localparam int LRSP_ID_W = 4;
    localparam int LRSP_PROT_W = 3;
    localparam int LRSP_WORDS = 16;
    localparam int LRSP_IDX_W = 4;
    localparam int LRSP_IDX_LSB = 2;
    localparam logic [1:0] LRSP_RESP_OKAY = 2'h0;
    localparam logic [1:0] LRSP_RESP_EXOKAY = 2'h1;
    localparam logic [1:0] LRSP_RESP_SLVERR = 2'h2;
    localparam logic [3:0] LRSP_CACHE_FIXED = 4'h0;
    localparam logic LRSP_LOCK_NORMAL = 1'b0;
    localparam logic LRSP_LAST_FIXED = 1'b1;
    localparam logic [LRSP_DATA_W-1:0] LRSP_DATA_ZERO = 32'h0000_0000;
    localparam logic [LRSP_ADDR_W-1:0] LRSP_ADDR_ZERO = 12'h000;
    localparam logic [LRSP_ID_W-1:0] LRSP_ID_ZERO = 4'h0;
    localparam logic [LRSP_STRB_W-1:0] LRSP_STRB_ZERO = 4'h0;
    localparam logic [LRSP_PROT_W-1:0] LRSP_PROT_ZERO = 3'h0;

    typedef enum logic [1:0] {
        LRSP_MST_IDLE = 2'b00,
        LRSP_MST_WRITE = 2'b01,
        LRSP_MST_READ = 2'b10
    } lrsp_mst_state_e;
endpackage

//--- hdl/lrsp_if.sv
/*
 * five-channel lite register link between a master end and the slave end.
 * assumes one clock and a synchronous active-high reset shared by both ends.
 */
`timescale 1ns/100ps
interface lrsp_if
    import lrsp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset
);
    logic awvalid;
    logic awready;
    logic [LRSP_ADDR_W-1:0] awaddr;
    logic [LRSP_PROT_W-1:0] awprot;
    logic [LRSP_ID_W-1:0] awid;
    logic wvalid;
    logic wready;
    logic [LRSP_DATA_W-1:0] wdata;
    logic [LRSP_STRB_W-1:0] wstrb;
    logic bvalid;
    logic bready;
    logic [1:0] bresp;
    logic [LRSP_ID_W-1:0] bid;
    logic arvalid;
    logic arready;
    logic [LRSP_ADDR_W-1:0] araddr;
    logic [LRSP_PROT_W-1:0] arprot;
    logic [LRSP_ID_W-1:0] arid;
    logic rvalid;
    logic rready;
    logic [LRSP_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [LRSP_ID_W-1:0] rid;

    modport slave (
        input clk_sys, reset,
        input awvalid, awaddr, awprot, awid, wvalid, wdata, wstrb, bready,
        input arvalid, araddr, arprot, arid, rready,
        output awready, wready, bvalid, bresp, bid, arready, rvalid, rdata, rresp, rid
    );
    modport master (
        input clk_sys, reset,
        output awvalid, awaddr, awprot, awid, wvalid, wdata, wstrb, bready,
        output arvalid, araddr, arprot, arid, rready,
        input awready, wready, bvalid, bresp, bid, arready, rvalid, rdata, rresp, rid
    );
endinterface

//--- hdl/lrsp_slave.sv
/*
 * slave end: a small word memory behind the lite link, with id reflection.
 * assumes the master keeps valid and payload steady until ready and sends
 * only single-beat full-width transfers; user side sees a write pulse.
 */
// What this block does
// - every transfer is a single beat
// - data bus fixed at 32 bits
// - accesses non-modifiable, non-bufferable
// - normal accesses only, no exclusives
// - never answer with exclusive okay
// - every data beat is the last
// - master supplies correct byte strobes
// - slave may honour, ignore or reject strobes
// - memory storage honours every strobe pattern
// - all-zero strobe write still gets response
// - outstanding count limited by holding ready low
// - responses return in address order
// - id of address returned with response
// - read data never interleaved
// - wide slave treats accesses full width
// - adapter needed for non-subset masters
// - direct full link only with subset traffic
`timescale 1ns/100ps
module lrsp_slave
    import lrsp_pkg::*;
(
    lrsp_if.slave bus,
    output logic [LRSP_DATA_W-1:0] word0_q,
    output logic wr_event_q
);
    // address and data are caught separately, so a master that sends one
    // channel ahead of the other is still served; the write lands on the
    // edge where the second half arrives, which keeps the response one
    // cycle behind the later of the two handshakes
    logic aw_rdy_q, aw_rdy_d, aw_full_q, aw_full_d;
    logic [LRSP_ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [LRSP_ID_W-1:0] aw_id_q, aw_id_d;
    logic w_rdy_q, w_rdy_d, w_full_q, w_full_d;
    logic [LRSP_DATA_W-1:0] w_data_q, w_data_d;
    logic [LRSP_STRB_W-1:0] w_strb_q, w_strb_d;
    logic [LRSP_DATA_W-1:0] mem_q [LRSP_WORDS];
    logic [LRSP_DATA_W-1:0] mem_d [LRSP_WORDS];
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic [LRSP_ID_W-1:0] bid_q, bid_d;
    logic ar_rdy_q, ar_rdy_d, rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [LRSP_ID_W-1:0] rid_q, rid_d;
    logic [LRSP_DATA_W-1:0] rdata_q, rdata_d, word0_d;
    logic wr_event_d;
    logic aw_hs, w_hs, ar_hs, commit;
    logic [LRSP_ADDR_W-1:0] wr_addr;
    logic [LRSP_ID_W-1:0] wr_id;
    logic [LRSP_DATA_W-1:0] wr_data;
    logic [LRSP_STRB_W-1:0] wr_strb;

    function automatic logic [LRSP_IDX_W-1:0] word_index(input logic [LRSP_ADDR_W-1:0] a);
        word_index = a[LRSP_IDX_LSB +: LRSP_IDX_W];
    endfunction

    // lanes with a clear strobe keep their old byte; an all-clear strobe
    // leaves the word untouched but the write is still answered
    function automatic logic [LRSP_DATA_W-1:0] merge_bytes(
            input logic [LRSP_DATA_W-1:0] old_word,
            input logic [LRSP_DATA_W-1:0] new_word,
            input logic [LRSP_STRB_W-1:0] strb);
        merge_bytes = old_word;
        for (int b = 0; b < LRSP_STRB_W; b++) begin
            if (strb[b]) begin
                merge_bytes[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
    endfunction

    assign aw_hs = bus.awvalid && aw_rdy_q;
    assign w_hs = bus.wvalid && w_rdy_q;
    assign ar_hs = bus.arvalid && ar_rdy_q;
    assign wr_addr = aw_full_q ? aw_addr_q : bus.awaddr;
    assign wr_id = aw_full_q ? aw_id_q : bus.awid;
    assign wr_data = w_full_q ? w_data_q : bus.wdata;
    assign wr_strb = w_full_q ? w_strb_q : bus.wstrb;
    assign commit = (aw_full_q || aw_hs) && (w_full_q || w_hs) && !bvalid_q;

    assign bus.awready = aw_rdy_q;
    assign bus.wready = w_rdy_q;
    assign bus.arready = ar_rdy_q;
    assign bus.bvalid = bvalid_q;
    assign bus.bresp = bresp_q;
    assign bus.bid = bid_q;
    assign bus.rvalid = rvalid_q;
    assign bus.rresp = rresp_q;
    assign bus.rid = rid_q;
    assign bus.rdata = rdata_q;

    always_comb begin
        aw_full_d = (aw_full_q || aw_hs) && !commit;
        aw_addr_d = aw_hs ? bus.awaddr : aw_addr_q;
        aw_id_d = aw_hs ? bus.awid : aw_id_q;
        w_full_d = (w_full_q || w_hs) && !commit;
        w_data_d = w_hs ? bus.wdata : w_data_q;
        w_strb_d = w_hs ? bus.wstrb : w_strb_q;
        // readys come from flops, so each half is refused once caught and
        // both stay low while a response waits: one write in flight at most
        aw_rdy_d = !aw_full_d && !bvalid_d;
        w_rdy_d = !w_full_d && !bvalid_d;
    end

    always_ff @(posedge bus.clk_sys) begin
        if (bus.reset) begin
            aw_rdy_q <= 1'b0;
            aw_full_q <= 1'b0;
            aw_addr_q <= LRSP_ADDR_ZERO;
            aw_id_q <= LRSP_ID_ZERO;
            w_rdy_q <= 1'b0;
            w_full_q <= 1'b0;
            w_data_q <= LRSP_DATA_ZERO;
            w_strb_q <= LRSP_STRB_ZERO;
        end else begin
            aw_rdy_q <= aw_rdy_d;
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            aw_id_q <= aw_id_d;
            w_rdy_q <= w_rdy_d;
            w_full_q <= w_full_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
        end
    end

    // attributes of the lite subset are fixed, so no cache, lock or last
    // field is decoded and every beat is a whole transfer
    always_comb begin
        mem_d = mem_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        bid_d = bid_q;
        if (bvalid_q && bus.bready) begin
            bvalid_d = 1'b0;
        end
        if (commit) begin
            mem_d[word_index(wr_addr)] = merge_bytes(mem_q[word_index(wr_addr)],
                wr_data, wr_strb);
            bvalid_d = 1'b1;
            bresp_d = LRSP_RESP_OKAY;
            bid_d = wr_id;
        end
    end

    always_ff @(posedge bus.clk_sys) begin
        if (bus.reset) begin
            for (int i = 0; i < LRSP_WORDS; i++) begin
                mem_q[i] <= LRSP_DATA_ZERO;
            end
            bvalid_q <= 1'b0;
            bresp_q <= LRSP_RESP_OKAY;
            bid_q <= LRSP_ID_ZERO;
        end else begin
            mem_q <= mem_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            bid_q <= bid_d;
        end
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rid_d = rid_q;
        rdata_d = rdata_q;
        if (rvalid_q && bus.rready) begin
            rvalid_d = 1'b0;
        end
        if (ar_hs) begin
            rvalid_d = 1'b1;
            rresp_d = LRSP_RESP_OKAY;
            rid_d = bus.arid;
            rdata_d = mem_q[word_index(bus.araddr)];
        end
        // the read address is refused while a beat waits, so beats never interleave
        ar_rdy_d = !rvalid_d;
    end

    always_ff @(posedge bus.clk_sys) begin
        if (bus.reset) begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= LRSP_RESP_OKAY;
            rid_q <= LRSP_ID_ZERO;
            rdata_q <= LRSP_DATA_ZERO;
        end else begin
            ar_rdy_q <= ar_rdy_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rid_q <= rid_d;
            rdata_q <= rdata_d;
        end
    end

    // user side: word 0 and a pulse for every answered write, empty strobes included
    always_comb begin
        word0_d = mem_d[0];
        wr_event_d = commit;
    end

    always_ff @(posedge bus.clk_sys) begin
        if (bus.reset) begin
            word0_q <= LRSP_DATA_ZERO;
            wr_event_q <= 1'b0;
        end else begin
            word0_q <= word0_d;
            wr_event_q <= wr_event_d;
        end
    end
endmodule

//--- hdl/lrsp_master.sv
/*
 * master end: turns one user command at a time into a lite transfer.
 * assumes the user holds cmd_valid until cmd_ready; answers come as a pulse.
 */
`timescale 1ns/100ps
module lrsp_master
    import lrsp_pkg::*;
(
    lrsp_if.master bus,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [LRSP_ADDR_W-1:0] cmd_addr,
    input wire logic [LRSP_DATA_W-1:0] cmd_wdata,
    input wire logic [LRSP_STRB_W-1:0] cmd_strb,
    input wire logic [LRSP_ID_W-1:0] cmd_id,
    output logic cmd_ready_q,
    output logic done_q,
    output logic [LRSP_DATA_W-1:0] done_rdata_q,
    output logic [1:0] done_resp_q,
    output logic [LRSP_ID_W-1:0] done_id_q
);
    lrsp_mst_state_e state_q, state_d;
    logic aw_q, aw_d, w_q, w_d, ar_q, ar_d;
    logic [LRSP_ADDR_W-1:0] addr_q, addr_d;
    logic [LRSP_DATA_W-1:0] wdata_q, wdata_d, rd_q, rd_d;
    logic [LRSP_STRB_W-1:0] strb_q, strb_d;
    logic [LRSP_ID_W-1:0] id_q, id_d, did_q, did_d;
    logic [1:0] resp_q, resp_d;
    logic rdy_d, done_d, br_q, br_d, rr_q, rr_d;

    assign bus.awvalid = aw_q;
    assign bus.awaddr = addr_q;
    assign bus.awprot = LRSP_PROT_ZERO;
    assign bus.awid = id_q;
    assign bus.wvalid = w_q;
    assign bus.wdata = wdata_q;
    assign bus.wstrb = strb_q;
    assign bus.arvalid = ar_q;
    assign bus.araddr = addr_q;
    assign bus.arprot = LRSP_PROT_ZERO;
    assign bus.arid = id_q;
    assign bus.bready = br_q;
    assign bus.rready = rr_q;

    always_comb begin
        state_d = state_q;
        aw_d = aw_q;
        w_d = w_q;
        ar_d = ar_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        strb_d = strb_q;
        id_d = id_q;
        rd_d = rd_q;
        did_d = did_q;
        resp_d = resp_q;
        rdy_d = 1'b0;
        done_d = 1'b0;
        unique case (state_q)
            LRSP_MST_IDLE: begin
                rdy_d = 1'b1;
                if (cmd_valid && cmd_ready_q) begin
                    rdy_d = 1'b0;
                    addr_d = cmd_addr;
                    wdata_d = cmd_wdata;
                    strb_d = cmd_strb;
                    id_d = cmd_id;
                    aw_d = cmd_write;
                    w_d = cmd_write;
                    ar_d = !cmd_write;
                    state_d = cmd_write ? LRSP_MST_WRITE : LRSP_MST_READ;
                end
            end
            LRSP_MST_WRITE: begin
                if (bus.awready) begin
                    aw_d = 1'b0;
                end
                if (bus.wready) begin
                    w_d = 1'b0;
                end
                if (bus.bvalid) begin
                    done_d = 1'b1;
                    resp_d = bus.bresp;
                    did_d = bus.bid;
                    rd_d = LRSP_DATA_ZERO;
                    state_d = LRSP_MST_IDLE;
                end
            end
            LRSP_MST_READ: begin
                if (bus.arready) begin
                    ar_d = 1'b0;
                end
                if (bus.rvalid) begin
                    done_d = 1'b1;
                    resp_d = bus.rresp;
                    did_d = bus.rid;
                    rd_d = bus.rdata;
                    state_d = LRSP_MST_IDLE;
                end
            end
            default: begin
                state_d = LRSP_MST_IDLE;
            end
        endcase
        // answer-ready is held by a flop for the whole open transfer
        br_d = (state_d == LRSP_MST_WRITE);
        rr_d = (state_d == LRSP_MST_READ);
    end

    always_ff @(posedge bus.clk_sys) begin
        if (bus.reset) begin
            state_q <= LRSP_MST_IDLE;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            ar_q <= 1'b0;
            addr_q <= LRSP_ADDR_ZERO;
            wdata_q <= LRSP_DATA_ZERO;
            strb_q <= LRSP_STRB_ZERO;
            id_q <= LRSP_ID_ZERO;
            rd_q <= LRSP_DATA_ZERO;
            did_q <= LRSP_ID_ZERO;
            resp_q <= LRSP_RESP_OKAY;
            cmd_ready_q <= 1'b0;
            done_q <= 1'b0;
            br_q <= 1'b0;
            rr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            aw_q <= aw_d;
            w_q <= w_d;
            ar_q <= ar_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            strb_q <= strb_d;
            id_q <= id_d;
            rd_q <= rd_d;
            did_q <= did_d;
            resp_q <= resp_d;
            cmd_ready_q <= rdy_d;
            done_q <= done_d;
            br_q <= br_d;
            rr_q <= rr_d;
        end
    end

    assign done_rdata_q = rd_q;
    assign done_resp_q = resp_q;
    assign done_id_q = did_q;
endmodule

//--- bench/lrsp_sva.sv
/*
 * checker for the lite link: response codes, id reflection, holding of answers.
 * assumes it sits beside the link interface, fed its signals, one clock.
 */
`timescale 1ns/100ps
module lrsp_sva
    import lrsp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [LRSP_ID_W-1:0] awid,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic [LRSP_ID_W-1:0] bid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [LRSP_ID_W-1:0] arid,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [LRSP_DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic [LRSP_ID_W-1:0] rid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_bresp_okay: assert property (bvalid |-> bresp == LRSP_RESP_OKAY)
        else $error("write response code not okay");
    a_rresp_okay: assert property (rvalid |-> rresp == LRSP_RESP_OKAY)
        else $error("read response code not okay");
    a_b_stays: assert property (bvalid && !bready |=> bvalid && $stable(bid))
        else $error("write response dropped or changed before handshake");
    a_r_stays: assert property (rvalid && !rready |=> rvalid && $stable({rid, rdata}))
        else $error("read beat dropped or changed before handshake");
    a_b_after_both: assert property ($rose(bvalid) |-> $past(awvalid && awready && wvalid && wready))
        else $error("write response without accepted address and data");
    a_aw_w_paired: assert property (awvalid && awready |-> wvalid && wready)
        else $error("address taken apart from its single data beat");
    a_bid_reflect: assert property (awvalid && awready |=> bvalid && bid == $past(awid))
        else $error("write response id differs from address id");
    a_rid_reflect: assert property (arvalid && arready |=> rvalid && rid == $past(arid))
        else $error("read beat id differs from address id");
    // one read outstanding: a pending beat must hold the read address off
    a_one_read: assert property (rvalid |-> !arready)
        else $error("read address accepted while a beat is pending");
    // a pending write response must hold both write channels off
    a_one_write: assert property (bvalid |-> !awready && !wready)
        else $error("write channel accepted while a response is pending");
endmodule

//--- bench/testbench.sv
/*
 * testbench: master and slave ends joined by the link, driven from the user side.
 * assumes the package, the interface and both ends are compiled first.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench
    import lrsp_pkg::*;
;
    localparam logic [LRSP_DATA_W-1:0] PAT = 32'h1122_3344;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [LRSP_ADDR_W-1:0] cmd_addr = LRSP_ADDR_ZERO;
    logic [LRSP_DATA_W-1:0] cmd_wdata = LRSP_DATA_ZERO;
    logic [LRSP_STRB_W-1:0] cmd_strb = LRSP_STRB_ZERO;
    logic [LRSP_ID_W-1:0] cmd_id = LRSP_ID_ZERO;
    logic cmd_ready_q, done_q, wr_event_q;
    logic [LRSP_DATA_W-1:0] done_rdata_q, word0_q, exp_d;
    logic [1:0] done_resp_q;
    logic [LRSP_ID_W-1:0] done_id_q;
    int num_errors = 0;
    int n_compared = 0;
    int n_wr = 0;
    int n_wr_exp = 0;

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (wr_event_q === 1'b1) n_wr++;

    lrsp_if u_if (.clk_sys(clk_sys), .reset(reset));
    lrsp_slave u_lrsp_slave (.bus(u_if.slave), .word0_q(word0_q), .wr_event_q(wr_event_q));
    lrsp_master u_lrsp_master (.bus(u_if.master), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_strb(cmd_strb), .cmd_id(cmd_id), .cmd_ready_q(cmd_ready_q), .done_q(done_q),
        .done_rdata_q(done_rdata_q), .done_resp_q(done_resp_q), .done_id_q(done_id_q));
    lrsp_sva u_lrsp_sva (.clk_sys(clk_sys), .reset(reset), .awvalid(u_if.awvalid),
        .awready(u_if.awready), .awid(u_if.awid), .wvalid(u_if.wvalid),
        .wready(u_if.wready), .bvalid(u_if.bvalid), .bready(u_if.bready),
        .bresp(u_if.bresp), .bid(u_if.bid), .arvalid(u_if.arvalid),
        .arready(u_if.arready), .arid(u_if.arid), .rvalid(u_if.rvalid),
        .rready(u_if.rready), .rdata(u_if.rdata), .rresp(u_if.rresp), .rid(u_if.rid));

    task automatic test_done();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // entered just after a rising edge; returns on a rising edge
    task automatic xfer(input logic wr, input logic [LRSP_ADDR_W-1:0] a,
            input logic [LRSP_DATA_W-1:0] d, input logic [LRSP_STRB_W-1:0] s,
            input logic [LRSP_ID_W-1:0] id, input logic [LRSP_DATA_W-1:0] e);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_strb <= s;
        cmd_id <= id;
        @(negedge clk_sys);
        while (cmd_ready_q !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        while (done_q !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK("done", 1'b1, done_q)
        `CHK("resp", LRSP_RESP_OKAY, done_resp_q)
        `CHK("id", id, done_id_q)
        if (wr === 1'b0) `CHK("rdata", e, done_rdata_q)
        n_wr_exp += int'(wr);
        @(posedge clk_sys);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        xfer(1'b0, 12'h00c, LRSP_DATA_ZERO, LRSP_STRB_ZERO, 4'h1, LRSP_DATA_ZERO);
        xfer(1'b1, 12'h000, 32'ha5a5_5a5a, 4'hf, 4'h3, LRSP_DATA_ZERO);
        `CHK("word0", 32'ha5a5_5a5a, word0_q)
        xfer(1'b1, 12'h000, 32'hffff_ffff, 4'h0, 4'h4, LRSP_DATA_ZERO);
        `CHK("word0_nostrb", 32'ha5a5_5a5a, word0_q)
        exp_d = LRSP_DATA_ZERO;
        for (int b = 0; b < 4; b++) begin
            xfer(1'b1, 12'h004, PAT, 4'h1 << b, 4'(b), LRSP_DATA_ZERO);
            exp_d[8*b +: 8] = PAT[8*b +: 8];
            xfer(1'b0, 12'h004, LRSP_DATA_ZERO, LRSP_STRB_ZERO, 4'(b), exp_d);
        end
        xfer(1'b1, 12'h008, 32'hdead_beef, 4'hc, 4'h5, LRSP_DATA_ZERO);
        xfer(1'b0, 12'h008, LRSP_DATA_ZERO, LRSP_STRB_ZERO, 4'h6, 32'hdead_0000);
        // upper address bits alias onto word 0; also walks every id value
        for (int i = 0; i < 16; i++) begin
            xfer(1'b0, 12'h040, LRSP_DATA_ZERO, LRSP_STRB_ZERO, 4'(i), 32'ha5a5_5a5a);
        end
        `CHK("wr_events", n_wr_exp, n_wr)
        test_done();
    end

    initial begin
        repeat (4000) @(posedge clk_sys);
        num_errors++;
        test_done();
    end
endmodule
